// ### hw/ovp_three_stage.v
// Three-stage definite-time overvoltage protection with Wishbone registers.
// Assumes line-to-line fundamental magnitudes on clk from the front end.
//
// Operation
// RL1: Only the three line-to-line fundamental magnitudes are evaluated, never phase voltages.
// RL2: A stage starts when any line-to-line magnitude exceeds its start setting.
// RL3: A started stage trips once the fault has lasted past its operate delay.
// RL4: Three independent stages (low, high, highest) with definite-time characteristic.
// RL5: The low stage keeps its operate timer after the fault clears until a release delay runs out.
// RL6: A low-stage fault returning within the release delay resumes the timer from its value.
// RL7: With 3 % hysteresis a fault stays until the voltage falls below 97 % of start.
// RL8: Hysteresis per stage is 0.1 % to 20.0 % of start in 0.1 % steps.
// RL9: Each stage has four setting groups of start, delays and hysteresis.
// RL10: Low and high stage start range 50 % to 150 %Un in 1 % steps.
// RL11: Highest stage start range 50 % to 160 %Un in 1 % steps.
// RL12: Low stage operate delay 0.08 s to 300.00 s in 0.02 s steps.
// RL13: High stage operate delay 0.06 s to 300.00 s in 0.02 s steps.
// RL14: Highest stage operate delay 0.04 s to 300.00 s in 0.01 s steps.
// RL15: Low stage release delay 0.06 s to 300.00 s in 0.02 s steps.
// RL16: Start, and trip of the upper stages, drop once all voltages are below start less hysteresis.
// RL17: Timers count a fixed 10 ms tick so every delay is a whole number of ticks.
//
// Chosen here: the placing of the registers and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
`include "ovp_regs.vh"

module ovp_three_stage #(
  parameter integer TICK_CYCLES = `OVP_TICK_CYCLES
) (
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Line-to-line magnitudes, 0.1 %Un per unit
  input  wire [15:0] uLineAB,
  input  wire [15:0] uLineBC,
  input  wire [15:0] uLineCA,
  // Protection outputs, bit 0 low stage, bit 2 highest stage
  output reg  [2:0]  startOut_ff,
  output reg  [2:0]  tripOut_ff,
  // Interrupt
  output wire        irq
);

  // Setting clamp at write time, so the timers never see an illegal value
  function [31:0] clampSetting;
    input [4:0]  idx;
    input [31:0] w;
    reg   [7:0]  st;
    reg   [7:0]  hy;
    reg   [7:0]  stMax;
    reg   [14:0] op;
    reg   [14:0] opMin;
    reg   [14:0] rl;
    begin
      st    = w[`OVP_START_LSB +: 8];
      hy    = w[`OVP_HYST_LSB +: 8];
      op    = w[`OVP_OPDLY_LSB +: 15];
      rl    = w[`OVP_RELDLY_LSB +: 15];
      stMax = (idx[4:3] == 2'h2) ? `OVP_START_MAX_HH : `OVP_START_MAX_LH; // [RL10] [RL11]
      opMin = (idx[4:3] == 2'h0) ? `OVP_OP_MIN_LOW :
              (idx[4:3] == 2'h1) ? `OVP_OP_MIN_HIGH : `OVP_OP_MIN_TOP;
      if (st < `OVP_START_MIN) st = `OVP_START_MIN;
      if (st > stMax) st = stMax;
      if (hy < `OVP_HYST_MIN) hy = `OVP_HYST_MIN; // [RL8]
      if (hy > `OVP_HYST_MAX) hy = `OVP_HYST_MAX; // [RL8]
      if (op < opMin) op = opMin; // [RL12] [RL13] [RL14]
      if (op > `OVP_DLY_MAX) op = `OVP_DLY_MAX;
      if (idx[4:3] != 2'h2) op[0] = 1'b0; // [RL12] [RL13]
      if (rl < `OVP_REL_MIN) rl = `OVP_REL_MIN; // [RL15]
      if (rl > `OVP_DLY_MAX) rl = `OVP_DLY_MAX;
      rl[0] = 1'b0; // [RL15]
      // Only the low stage has a release delay; the others are stored as zero on a write
      if (idx[4:3] != 2'h0) rl = 15'h0000;
      if (idx[0]) begin
        clampSetting = {1'b0, rl, 1'b0, op};
      end else begin
        clampSetting = {16'h0000, hy, st};
      end
    end
  endfunction

  // Register select, shared by the write, clear and read paths
  function [3:0] regHit;
    input [7:0] adr;
    begin
      regHit = 4'h0;
      if (adr == `OVP_CTRL_OFS) begin
        regHit = 4'h1;
      end else if (adr == `OVP_STATE_OFS) begin
        regHit = 4'h2;
      end else if (adr == `OVP_IRQ_STAT_OFS) begin
        regHit = 4'h4;
      end else if (adr == `OVP_IRQ_MASK_OFS) begin
        regHit = 4'h8;
      end
    end
  endfunction

  // Bus handshake: one wait cycle so memory read data is registered
  reg         reqSeen_ff;
  reg  [2:0]  ctrl_ff;
  reg  [5:0]  irqStat_ff;
  reg  [5:0]  irqMask_ff;
  wire        busReq   = wb_cyc_i & wb_stb_i;
  wire        doAccess = reqSeen_ff & ~wb_ack_o & busReq;
  wire        isSet    = (wb_adr_i >= `OVP_SET_BASE_OFS) && (wb_adr_i <= `OVP_SET_LAST_OFS);
  wire [7:0]  setOfs   = wb_adr_i - `OVP_SET_BASE_OFS;
  wire [4:0]  setIdx   = setOfs[6:2];
  wire [31:0] busRd;
  wire [31:0] scanRd;
  wire [31:0] merged;
  wire [3:0]  regSel   = regHit(wb_adr_i);
  wire        setWr    = doAccess & wb_we_i & isSet;
  wire        enable   = ctrl_ff[`OVP_CTRL_EN_BIT];
  wire [1:0]  group    = ctrl_ff[`OVP_CTRL_GRP_LSB +: 2];

  // Byte lanes not selected keep the stored setting
  genvar b;
  generate
    for (b = 0; b < 4; b = b + 1) begin : lane
      assign merged[8*b +: 8] = wb_sel_i[b] ? wb_dat_i[8*b +: 8] : busRd[8*b +: 8];
    end
  endgenerate

  // Scanner copies the active group of each stage into working registers
  reg  [2:0]  scanIdx_ff;
  reg  [2:0]  scanPrev_ff;
  reg         scanValid_ff;
  wire [4:0]  scanAddr = {scanIdx_ff[2:1], group, scanIdx_ff[0]}; // [RL9]

  ovp_setting_mem settings (
    .clk        (clk),
    .reset      (reset),
    .wrEn       (setWr),
    .wrAddr     (setIdx),
    .wrData     (clampSetting(setIdx, merged)),
    .rdAddrA    (setIdx),
    .rdDataA_ff (busRd),
    .rdAddrB    (scanAddr),
    .rdDataB_ff (scanRd)
  );

  always @(posedge clk) begin
    if (reset) begin
      scanIdx_ff   <= 3'h0;
      scanPrev_ff  <= 3'h0;
      scanValid_ff <= 1'b0;
    end else begin
      scanIdx_ff   <= (scanIdx_ff == 3'h5) ? 3'h0 : scanIdx_ff + 3'h1;
      scanPrev_ff  <= scanIdx_ff;
      scanValid_ff <= 1'b1;
    end
  end

  // Protection tick
  reg  [19:0] tickCnt_ff;
  wire        tick = (tickCnt_ff == TICK_CYCLES[19:0] - 20'h00001); // [RL17]

  always @(posedge clk) begin
    if (reset || tick) begin
      tickCnt_ff <= 20'h00000;
    end else begin
      tickCnt_ff <= tickCnt_ff + 20'h00001;
    end
  end

  // Voltages scaled once; no phase-to-neutral input exists at all
  wire [22:0] vAB = uLineAB * `OVP_VOLT_SCALE; // [RL1]
  wire [22:0] vBC = uLineBC * `OVP_VOLT_SCALE; // [RL1]
  wire [22:0] vCA = uLineCA * `OVP_VOLT_SCALE; // [RL1]

  wire [2:0]  faultNow;
  wire [2:0]  nxt_start;
  wire [2:0]  nxt_trip;

  // Stage state lives inside each generate block so every flop has one driver
  genvar s;
  generate
    for (s = 0; s < 3; s = s + 1) begin : stage
      reg  [7:0]  actStart_ff;
      reg  [7:0]  actHyst_ff;
      reg  [14:0] actOp_ff;
      reg  [14:0] actRel_ff;
      reg  [14:0] timer_ff;
      reg  [14:0] relCnt_ff;
      reg         fault_ff;
      wire [22:0] startLvl = actStart_ff * `OVP_START_SCALE;
      wire [22:0] relLvl   = actStart_ff * (`OVP_START_SCALE - {15'h0000, actHyst_ff});
      wire        overV    = (vAB > startLvl) | (vBC > startLvl) | (vCA > startLvl); // [RL2]
      wire        belowRel = (vAB < relLvl) & (vBC < relLvl) & (vCA < relLvl); // [RL7] [RL16]
      wire        hit      = scanValid_ff && (scanPrev_ff[2:1] == s);
      wire        opDone   = (timer_ff >= actOp_ff);

      assign faultNow[s]  = overV | (fault_ff & ~belowRel); // [RL7]
      assign nxt_start[s] = faultNow[s]; // [RL2] [RL16]
      assign nxt_trip[s]  = faultNow[s] & opDone; // [RL3] [RL4] [RL16]

      always @(posedge clk) begin
        if (reset) begin
          actStart_ff <= 8'h78;
          actHyst_ff  <= 8'h1E;
          actOp_ff    <= 15'h0064;
          actRel_ff   <= 15'h0064;
        end else if (hit && !scanPrev_ff[0]) begin
          actStart_ff <= scanRd[`OVP_START_LSB +: 8];
          actHyst_ff  <= scanRd[`OVP_HYST_LSB +: 8];
        end else if (hit) begin
          actOp_ff    <= scanRd[`OVP_OPDLY_LSB +: 15];
          actRel_ff   <= scanRd[`OVP_RELDLY_LSB +: 15];
        end
      end

      // Definite-time stage; only the low stage holds its timer through gaps
      always @(posedge clk) begin
        if (reset || !enable) begin
          fault_ff  <= 1'b0;
          timer_ff  <= 15'h0000;
          relCnt_ff <= 15'h0000;
        end else begin
          fault_ff <= faultNow[s];
          if (faultNow[s]) begin
            relCnt_ff <= 15'h0000; // [RL6]
            if (tick && !opDone) begin
              timer_ff <= timer_ff + 15'h0001; // [RL3] [RL17]
            end
          end else if (s == 0) begin
            // Timer kept through short gaps so intermittent faults add up
            if (tick && (timer_ff != 15'h0000)) begin
              if (relCnt_ff + 15'h0001 >= actRel_ff) begin
                timer_ff  <= 15'h0000; // [RL5]
                relCnt_ff <= 15'h0000;
              end else begin
                relCnt_ff <= relCnt_ff + 15'h0001; // [RL5]
              end
            end
          end else begin
            timer_ff  <= 15'h0000;
            relCnt_ff <= 15'h0000;
          end
        end
      end
    end
  endgenerate

  // Start and trip outputs registered together; disable drops them at once
  always @(posedge clk) begin
    if (reset || !enable) begin
      startOut_ff <= 3'h0;
      tripOut_ff  <= 3'h0;
    end else begin
      startOut_ff <= nxt_start;
      tripOut_ff  <= nxt_trip;
    end
  end

  // Interrupt events: rising start and trip; a new event beats a clear
  reg  [5:0]  prevOut_ff;
  wire [5:0]  curOut  = {tripOut_ff, startOut_ff};
  wire [5:0]  events  = curOut & ~prevOut_ff;
  wire        w1cHit  = doAccess & wb_we_i & regSel[2] & wb_sel_i[0];
  wire [5:0]  clrBits = w1cHit ? wb_dat_i[5:0] : 6'h00;

  assign irq = |(irqStat_ff & irqMask_ff);

  always @(posedge clk) begin
    if (reset) begin
      prevOut_ff <= 6'h00;
      irqStat_ff <= 6'h00;
    end else begin
      prevOut_ff <= curOut;
      irqStat_ff <= (irqStat_ff & ~clrBits) | events;
    end
  end

  // Control and interrupt mask register writes
  always @(posedge clk) begin
    if (reset) begin
      ctrl_ff    <= `OVP_CTRL_RESET;
      irqMask_ff <= 6'h00;
    end else if (doAccess && wb_we_i && wb_sel_i[0]) begin
      if (regSel[0]) begin
        ctrl_ff <= wb_dat_i[2:0];
      end else if (regSel[3]) begin
        irqMask_ff <= wb_dat_i[5:0];
      end
    end
  end

  // Read mux, registered below so read data stand until the next read
  reg  [31:0] nxt_rdData;

  always @* begin
    nxt_rdData = 32'h00000000;
    if (regSel[0]) begin
      nxt_rdData = {29'h00000000, ctrl_ff};
    end else if (regSel[1]) begin
      nxt_rdData = {26'h0000000, tripOut_ff, startOut_ff};
    end else if (regSel[2]) begin
      nxt_rdData = {26'h0000000, irqStat_ff};
    end else if (regSel[3]) begin
      nxt_rdData = {26'h0000000, irqMask_ff};
    end else if (isSet) begin
      nxt_rdData = busRd;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      reqSeen_ff <= 1'b0;
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 32'h00000000;
    end else begin
      reqSeen_ff <= busReq & ~wb_ack_o & ~reqSeen_ff;
      wb_ack_o   <= doAccess;
      if (doAccess && !wb_we_i) begin
        wb_dat_o <= nxt_rdData;
      end
    end
  end

endmodule // ovp_three_stage
`default_nettype wire

// ### hw/ovp_regs.vh
// Register map, field layout, setting limits and timing counts of the
// overvoltage protection block. Definitions only; included by bare name.
`ifndef OVP_REGS_VH
`define OVP_REGS_VH

// Register byte offsets
`define OVP_CTRL_OFS       8'h00
`define OVP_STATE_OFS      8'h04
`define OVP_IRQ_STAT_OFS   8'h08
`define OVP_IRQ_MASK_OFS   8'h0C
`define OVP_SET_BASE_OFS   8'h40
`define OVP_SET_LAST_OFS   8'h9C

// Control fields
`define OVP_CTRL_EN_BIT    0
`define OVP_CTRL_GRP_LSB   1
`define OVP_CTRL_RESET     3'h0

// Setting word 0: start in 1 %Un, hysteresis in 0.1 % of start
`define OVP_START_LSB      0
`define OVP_HYST_LSB       8
// Setting word 1: operate and release delay in protection ticks
`define OVP_OPDLY_LSB      0
`define OVP_RELDLY_LSB     16

// Setting limits
`define OVP_START_MIN      8'h32
`define OVP_START_MAX_LH   8'h96
`define OVP_START_MAX_HH   8'hA0
`define OVP_HYST_MIN       8'h01
`define OVP_HYST_MAX       8'hC8
`define OVP_DLY_MAX        15'h7530
`define OVP_OP_MIN_LOW     15'h0008
`define OVP_OP_MIN_HIGH    15'h0006
`define OVP_OP_MIN_TOP     15'h0004
`define OVP_REL_MIN        15'h0006

// Setting reset values: start 120 %, hysteresis 3 %, delays 1 s
`define OVP_SET0_RESET     32'h00001E78
`define OVP_SET1_RESET     32'h00640064

// Voltage scale: inputs in 0.1 %Un, start in 1 %Un
`define OVP_VOLT_SCALE     23'h000064
`define OVP_START_SCALE    23'h0003E8

// Timing: 10 ns clock, 10 ms protection tick
`define OVP_CLK_NS         10
`define OVP_TICK_NS        10000000
`define OVP_TICK_CYCLES    (`OVP_TICK_NS / `OVP_CLK_NS)

`endif

// ### hw/ovp_setting_mem.v
// Setting store: 24 words, one write port, two registered read ports.
// Assumes one clock and a synchronous active-high reset that loads defaults.
`timescale 1ns/10ps
`default_nettype none
`include "ovp_regs.vh"

module ovp_setting_mem (
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // Write port
  input  wire        wrEn,
  input  wire [4:0]  wrAddr,
  input  wire [31:0] wrData,
  // Bus read port
  input  wire [4:0]  rdAddrA,
  output reg  [31:0] rdDataA_ff,
  // Scan read port
  input  wire [4:0]  rdAddrB,
  output reg  [31:0] rdDataB_ff
);

  reg [31:0] mem [0:23];
  integer    i;

  always @(posedge clk) begin
    if (reset) begin
      for (i = 0; i < 24; i = i + 1) begin
        mem[i] <= i[0] ? `OVP_SET1_RESET : `OVP_SET0_RESET;
      end
    end else if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      rdDataA_ff <= 32'h00000000;
      rdDataB_ff <= 32'h00000000;
    end else begin
      rdDataA_ff <= mem[rdAddrA];
      rdDataB_ff <= mem[rdAddrB];
    end
  end

endmodule // ovp_setting_mem
`default_nettype wire

// ### bench/volt_front_end.sv
// Front-end model: line-to-line magnitudes, 0.1 %Un per unit.
// Assumes the bench picks one line to raise; the others sit at rated voltage.
`timescale 1ns/10ps
`default_nettype none
module volt_front_end (
  // Clock
  input  wire logic        clk,
  // Requested value
  input  wire logic [15:0] level,
  input  wire logic [1:0]  lineSel,
  // Magnitudes
  output logic      [15:0] uLineAB,
  output logic      [15:0] uLineBC,
  output logic      [15:0] uLineCA
);
  // Registered, like a real filter stage, so values change only on an edge
  always_ff @(posedge clk) begin
    uLineAB <= (lineSel == 2'h0) ? level : 16'h03E8;
    uLineBC <= (lineSel == 2'h1) ? level : 16'h03E8;
    uLineCA <= (lineSel == 2'h2) ? level : 16'h03E8;
  end
endmodule // volt_front_end
`default_nettype wire

// ### bench/ovp_three_stage_chk.sv
// Port checker for the overvoltage block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module ovp_three_stage_chk #(
  parameter integer TICK_CYCLES = 1000000
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Bus
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_ack_o,
  // Magnitudes and outputs
  input  wire logic [15:0] uLineAB,
  input  wire logic [15:0] uLineBC,
  input  wire logic [15:0] uLineCA,
  input  wire logic [2:0]  startOut_ff,
  input  wire logic [2:0]  tripOut_ff,
  input  wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic        req;
  logic [15:0] vMax;
  int          topRun;
  assign req = wb_cyc_i && wb_stb_i;
  always_comb begin
    vMax = (uLineAB > uLineBC) ? uLineAB : uLineBC;
    if (uLineCA > vMax)
      vMax = uLineCA;
  end
  // Cycles the highest stage has been started without a break
  always_ff @(posedge clk) begin
    if (reset || !startOut_ff[2])
      topRun <= 0;
    else
      topRun <= topRun + 1;
  end
  sequence reqStart_s;
    req && !$past(wb_cyc_i);
  endsequence
  sequence ackPulse_s;
    ##2 wb_ack_o ##1 !wb_ack_o;
  endsequence
  ack_latency_a: assert property (reqStart_s |-> ackPulse_s)
    else $error("ack not two cycles after request");
  ack_cause_a: assert property (wb_ack_o |-> $past(req, 2))
    else $error("ack without request");
  trip_start_a: assert property ((tripOut_ff & ~startOut_ff) == 3'h0)
    else $error("trip without start");
  trip_order_a: assert property ((tripOut_ff & ~$past(tripOut_ff) & ~$past(startOut_ff)) == 3'h0)
    else $error("trip rose before start");
  start_cause_a: assert property ((startOut_ff & ~$past(startOut_ff)) != 3'h0 |-> $past(vMax) > 16'h01F4)
    else $error("start with no overvoltage");
  start_release_a: assert property (vMax < 16'h0190 |=> startOut_ff == 3'h0)
    else $error("start held below any hysteresis band");
  irq_clear_a: assert property ($fell(irq) |-> wb_ack_o && wb_we_i)
    else $error("interrupt fell without a write");
  top_delay_a: assert property ($rose(tripOut_ff[2]) |-> topRun >= 3 * TICK_CYCLES - 1)
    else $error("highest stage tripped too early");
endmodule // ovp_three_stage_chk
bind ovp_three_stage ovp_three_stage_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_i (
  .clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_ack_o(wb_ack_o), .uLineAB(uLineAB), .uLineBC(uLineBC), .uLineCA(uLineCA),
  .startOut_ff(startOut_ff), .tripOut_ff(tripOut_ff), .irq(irq));
`default_nettype wire

// ### bench/ovp_three_stage_tb.sv
// Self-checking bench for the three-stage overvoltage block.
// Assumes the front-end model and the bound checker are compiled with it.
`timescale 1ns/10ps
`default_nettype none
module ovp_three_stage_tb;
  localparam int TICK = 10;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        wbCyc = 1'b0;
  logic        wbStb = 1'b0;
  logic        wbWe = 1'b0;
  logic [7:0]  wbAdr = 8'h00;
  logic [3:0]  wbSel = 4'h0;
  logic [31:0] wbDatW = 32'h0;
  logic [31:0] wbDatR;
  logic        wbAck;
  logic [15:0] level = 16'h03E8;
  logic [1:0]  lineSel = 2'h0;
  logic [15:0] uAB, uBC, uCA;
  logic [2:0]  startV, tripV;
  logic        irq;
  int          err_total = 0;
  int          check_count = 0;
  volt_front_end volt_front_end_i (.clk(clk), .level(level), .lineSel(lineSel),
    .uLineAB(uAB), .uLineBC(uBC), .uLineCA(uCA));
  // Short tick keeps a 300 s count out of reach but the small delays cheap
  ovp_three_stage #(.TICK_CYCLES(TICK)) ovp_three_stage_i (.clk(clk), .reset(reset),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .uLineAB(uAB), .uLineBC(uBC),
    .uLineCA(uCA), .startOut_ff(startV), .tripOut_ff(tripV), .irq(irq));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic complete_run;
    $display("Checks %0d, errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    check_count++;
    if (seen !== expv) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, expv);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Entered just after an edge; holds the request until ack is sampled
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= wr;
    wbAdr <= a;
    wbSel <= 4'hF;
    wbDatW <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 16);
    q = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    if (wbAck !== 1'b1) begin
      err_total++;
      complete_run();
    end
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, e);
  endtask
  task automatic setV(input logic [1:0] k, input logic [15:0] v);
    lineSel <= k;
    level <= v;
  endtask
  task automatic settingLimits;
    logic [7:0]  adr [8] = '{8'h40, 8'h80, 8'h64, 8'h84, 8'h44, 8'h40, 8'h80, 8'h64};
    logic [31:0] wd [8] = '{32'h000000C8, 32'h0000FFC8, 32'h00007FFF, 32'h00000003,
                            32'h00020002, 32'h00001E78, 32'h00001E78, 32'h00000006};
    logic [31:0] ex [8] = '{32'h00000196, 32'h0000C8A0, 32'h00007530, 32'h00000004,
                            32'h00060008, 32'h00001E78, 32'h00001E78, 32'h00000006};
    rdChk(8'h00, 32'h0);
    rdChk(8'h40, 32'h00001E78);
    rdChk(8'h44, 32'h00640064);
    rdChk(8'h20, 32'h0);
    for (int i = 0; i < 8; i++) begin
      wr(adr[i], wd[i]);
      rdChk(adr[i], ex[i]);
    end
    wr(8'h0C, 32'h0000003F);
    wr(8'h00, 32'h00000001);
    cyc(10);
  endtask
  task automatic eachLine;
    for (int k = 0; k < 3; k++) begin
      setV(k[1:0], 16'd1200);
      cyc(5);
      check({29'h0, startV}, 32'h0);
      setV(k[1:0], 16'd1201);
      cyc(4);
      check({29'h0, startV}, 32'h7);
      setV(k[1:0], 16'd1000);
      cyc(4);
      check({29'h0, startV}, 32'h0);
    end
    cyc(100);
  endtask
  task automatic tripTiming;
    int t [3] = '{-1, -1, -1};
    int op [3] = '{8, 6, 4};
    setV(2'h0, 16'd1300);
    for (int n = 0; n < 100; n++) begin
      @(posedge clk);
      for (int k = 0; k < 3; k++)
        if (tripV[k] === 1'b1 && t[k] < 0)
          t[k] = n;
    end
    for (int k = 0; k < 3; k++)
      check({31'h0, t[k] >= (op[k] - 1) * TICK && t[k] <= op[k] * TICK + 4}, 32'h1);
    rdChk(8'h04, 32'h0000003F);
    setV(2'h0, 16'd1164);
    cyc(4);
    check({26'h0, tripV, startV}, 32'h3F);
    setV(2'h0, 16'd1163);
    cyc(4);
    check({26'h0, tripV, startV}, 32'h0);
    cyc(100);
  endtask
  task automatic releaseDelay;
    int n;
    wr(8'h60, 32'h00001E96);
    wr(8'h80, 32'h00001EA0);
    cyc(10);
    setV(2'h0, 16'd1201);
    cyc(50);
    setV(2'h0, 16'd1000);
    cyc(30);
    setV(2'h0, 16'd1201);
    n = 0;
    while (tripV[0] !== 1'b1 && n < 55) begin
      @(posedge clk);
      n++;
    end
    check({31'h0, tripV[0]}, 32'h1);
    setV(2'h0, 16'd1000);
    cyc(100);
    setV(2'h0, 16'd1201);
    cyc(45);
    check({29'h0, tripV}, 32'h0);
    setV(2'h0, 16'd1000);
    cyc(10);
  endtask
  task automatic groupAndIrq;
    wr(8'h48, 32'h00001E3C);
    wr(8'h00, 32'h00000003);
    cyc(10);
    setV(2'h1, 16'd700);
    cyc(4);
    check({29'h0, startV}, 32'h1);
    setV(2'h1, 16'd1000);
    cyc(4);
    check({31'h0, irq}, 32'h1);
    wr(8'h0C, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr(8'h0C, 32'h00000001);
    check({31'h0, irq}, 32'h1);
    wr(8'h08, 32'h0000003F);
    check({31'h0, irq}, 32'h0);
    rdChk(8'h08, 32'h0);
  endtask
  initial begin
    cyc(16);
    reset <= 1'b0;
    cyc(2);
    settingLimits();
    eachLine();
    tripTiming();
    releaseDelay();
    groupAndIrq();
    complete_run();
  end
endmodule // ovp_three_stage_tb
`default_nettype wire
